// File: rtl/jtag_config_port_bridge.sv
// What this block does
// - monitor register reachable only with instruction 1111110111 loaded
// - monitor data register is 32 bits for every command
// - with that opcode loaded, each data scan uses the monitor register
// - on Update-DR the shifted command goes to the port arbiter
// - a handed write reaches the port within six port clocks when no fabric transaction holds the port
// - Capture-DR loads arbiter data, shifted out lsb first on TDO
// - captured word holds port data low, zeros in upper 16 bits
// - read takes two scans: command, then capture of latched 16 bits
// - capture before a read finishes returns the older held data
// - next read command shifts in while previous result shifts out
// - command: data [15:0], address [25:16], operation [29:26]
// - operation 0 nop, 1 read, 2 write, others undefined
// - before configuration, writing 0001h to 02h enables auxiliary inputs
// - that auxiliary enable works only before configuration
// - port granted one whole read or write transaction at a time
// - fabric request during tap transaction waits until it finishes
// - tap request during fabric transaction waits for it to complete
// - pending flag rises at update, falls at completion; fabric ready after
// - wrote flag rises after tap write, falls on next port access
// - 0001h to 00h locks, 0000h unlocks; locked fabric access refused
`include "jtag_config_port_bridge_consts.svh"
`default_nettype none

module jtag_config_port_bridge
  import jtag_config_port_bridge_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic tck_i,
  input wire logic tdi_i,
  output logic tdo_o,
  input wire logic [`IR_WIDTH-1:0] ir_value_i,
  input wire logic capture_dr_i,
  input wire logic shift_dr_i,
  input wire logic update_dr_i,
  input wire logic configured_i,
  input wire logic fab_en_i,
  input wire logic fab_we_i,
  input wire logic [`PORT_ADDR_WIDTH-1:0] fab_addr_i,
  input wire logic [`PORT_DATA_WIDTH-1:0] fab_di_i,
  output logic [`PORT_DATA_WIDTH-1:0] fab_do_o,
  output logic fab_ready_o,
  output logic fab_refused_o,
  output logic cfg_en_o,
  output logic cfg_we_o,
  output logic [`PORT_ADDR_WIDTH-1:0] cfg_addr_o,
  output logic [`PORT_DATA_WIDTH-1:0] cfg_di_o,
  input wire logic [`PORT_DATA_WIDTH-1:0] cfg_do_i,
  input wire logic cfg_ready_i,
  output logic tap_transaction_pending_o,
  output logic tap_wrote_flag_o,
  output logic tap_lockout_flag_o,
  output logic aux_inputs_en_o
);

  localparam int SYNC_W = `IR_WIDTH + 5;

  // every check below lives on the one core clock
  default clocking core_cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // two-stage synchronisers for everything from the tck side
  logic [SYNC_W-1:0] sync_a;
  logic [SYNC_W-1:0] sync_b;
  logic [SYNC_W-1:0] sync_c;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      sync_a <= '0;
      sync_b <= '0;
      sync_c <= '0;
    end else begin
      sync_a <= {ir_value_i, update_dr_i, shift_dr_i, capture_dr_i,
                 tdi_i, tck_i};
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  // state levels are taken from the older stage so that a state change
  // right after a tck rise cannot race the edge detector
  logic tck_rise, tck_fall, tdi_s, capture_s, shift_s;
  logic update_now, update_old, selected;
  logic [`IR_WIDTH-1:0] ir_s;

  assign tck_rise = sync_b[0] && !sync_c[0];
  assign tck_fall = !sync_b[0] && sync_c[0];
  assign tdi_s = sync_b[1];
  assign capture_s = sync_c[2];
  assign shift_s = sync_c[3];
  assign update_now = sync_b[4];
  assign update_old = sync_c[4];
  assign ir_s = sync_c[SYNC_W-1:5];
  assign selected = (ir_s == `MONITOR_ACCESS_OPCODE);

  // held port data and the capture image for the data register
  logic [`PORT_DATA_WIDTH-1:0] held_data;
  logic [`CMD_WIDTH-1:0] capture_word, dr_word;
  logic dr_serial, do_capture, do_shift;

  assign capture_word = {`CAPTURE_PAD, held_data};
  assign do_capture = tck_rise && capture_s && selected;
  assign do_shift = tck_rise && shift_s && selected;

  tap_data_register #(
    .WIDTH(`CMD_WIDTH)
  ) u_dr (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .capture_i(do_capture),
    .shift_i(do_shift),
    .serial_i(tdi_s),
    .load_i(capture_word),
    .word_o(dr_word),
    .serial_o(dr_serial)
  );

  // tdo moves on the falling tck edge, as the tester samples on the rise
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      tdo_o <= 1'b0;
    end else if (tck_fall) begin
      tdo_o <= dr_serial;
    end
  end

  // command fields of the shifted word
  port_op_t dr_op;
  logic dr_valid;
  logic update_take;

  assign dr_op = dr_word[`CMD_OP_MSB:`CMD_OP_LSB];
  assign dr_valid = (dr_op == `OP_READ) || (dr_op == `OP_WRITE);
  assign update_take = update_now && !update_old && selected;

  // tap command latched at update; nop and undefined codes are dropped
  logic tap_we;
  logic [`PORT_ADDR_WIDTH-1:0] tap_addr;
  logic [`PORT_DATA_WIDTH-1:0] tap_data;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      tap_we <= 1'b0;
      tap_addr <= '0;
      tap_data <= '0;
    end else if (update_take && dr_valid) begin
      tap_we <= (dr_op == `OP_WRITE);
      tap_addr <= dr_word[`CMD_ADDR_MSB:`CMD_ADDR_LSB];
      tap_data <= dr_word[`CMD_DATA_MSB:`CMD_DATA_LSB];
    end
  end

  // fabric request queue of one, the fabric may not issue another
  // before its ready strobe so one slot is enough
  logic fab_pend, fab_we, fab_done;
  logic [`PORT_ADDR_WIDTH-1:0] fab_addr;
  logic [`PORT_DATA_WIDTH-1:0] fab_data;
  arb_state_e state;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      fab_pend <= 1'b0;
      fab_we <= 1'b0;
      fab_addr <= '0;
      fab_data <= '0;
    end else if (fab_en_i && !fab_pend) begin
      fab_pend <= 1'b1;
      fab_we <= fab_we_i;
      fab_addr <= fab_addr_i;
      fab_data <= fab_di_i;
    end else if (fab_done) begin
      fab_pend <= 1'b0;
    end
  end

  // grant decisions in idle; tap goes first when both wait
  logic grant_tap, grant_fab, refuse_fab, tap_done;

  assign grant_tap = (state == ARB_IDLE) && tap_transaction_pending_o;
  assign grant_fab = (state == ARB_IDLE) && !tap_transaction_pending_o &&
                     fab_pend && !tap_lockout_flag_o;
  assign refuse_fab = (state == ARB_IDLE) && !tap_transaction_pending_o &&
                      fab_pend && tap_lockout_flag_o;
  assign tap_done = (state == ARB_TAP) && cfg_ready_i;
  assign fab_done = ((state == ARB_FAB) && cfg_ready_i) || refuse_fab;

  // arbiter: a started transaction always runs to its ready
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      state <= ARB_IDLE;
    end else begin
      case (state)
        ARB_IDLE: begin
          if (grant_tap) begin
            state <= ARB_TAP;
          end else if (grant_fab) begin
            state <= ARB_FAB;
          end
        end
        ARB_FAB: begin
          if (cfg_ready_i) begin
            state <= ARB_IDLE;
          end
        end
        ARB_TAP: begin
          if (cfg_ready_i) begin
            state <= ARB_IDLE;
          end
        end
        default: begin
          state <= ARB_IDLE;
        end
      endcase
    end
  end

  // port request, one-cycle enable with its fields
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cfg_en_o <= 1'b0;
      cfg_we_o <= 1'b0;
      cfg_addr_o <= '0;
      cfg_di_o <= '0;
    end else begin
      cfg_en_o <= grant_tap || grant_fab;
      if (grant_tap) begin
        cfg_we_o <= tap_we;
        cfg_addr_o <= tap_addr;
        cfg_di_o <= tap_data;
      end else if (grant_fab) begin
        cfg_we_o <= fab_we;
        cfg_addr_o <= fab_addr;
        cfg_di_o <= fab_data;
      end
    end
  end

  // pending flag; a new update wins over the completion of the old one
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      tap_transaction_pending_o <= 1'b0;
    end else if (update_take && dr_valid) begin
      tap_transaction_pending_o <= 1'b1;
    end else if (tap_done) begin
      tap_transaction_pending_o <= 1'b0;
    end
  end

  // read result held until the next tap read finishes
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      held_data <= `HELD_DATA_RESET;
    end else if (tap_done && !cfg_we_o) begin
      held_data <= cfg_do_i;
    end
  end

  // fabric answer, data from a register, refusal flagged alongside
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      fab_ready_o <= 1'b0;
      fab_refused_o <= 1'b0;
      fab_do_o <= '0;
    end else begin
      fab_ready_o <= fab_done;
      fab_refused_o <= refuse_fab;
      if ((state == ARB_FAB) && cfg_ready_i && !cfg_we_o) begin
        fab_do_o <= cfg_do_i;
      end
    end
  end

  // wrote flag: set by a finished tap write wins over a new start
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      tap_wrote_flag_o <= 1'b0;
    end else if (tap_done && cfg_we_o) begin
      tap_wrote_flag_o <= 1'b1;
    end else if (cfg_en_o) begin
      tap_wrote_flag_o <= 1'b0;
    end
  end

  // lockout changes only by tap writes; other values at 00h leave it
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      tap_lockout_flag_o <= 1'b0;
    end else if (tap_done && cfg_we_o && (cfg_addr_o == `LOCK_ADDR)) begin
      if (cfg_di_o == `LOCK_SET_VALUE) begin
        tap_lockout_flag_o <= 1'b1;
      end else if (cfg_di_o == `LOCK_CLEAR_VALUE) begin
        tap_lockout_flag_o <= 1'b0;
      end
    end
  end

  // aux enable sticks once set; after configuration the design owns
  // the inputs, so the enable is dropped and no longer settable
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      aux_inputs_en_o <= 1'b0;
    end else if (configured_i) begin
      aux_inputs_en_o <= 1'b0;
    end else if (cfg_en_o && cfg_we_o &&
                 (cfg_addr_o == `AUX_ENABLE_ADDR) &&
                 (cfg_di_o == `AUX_ENABLE_VALUE)) begin
      aux_inputs_en_o <= 1'b1;
    end
  end

  // cycles a tap write waits for its grant; the port's own latency
  // after the grant is not the arbiter's to bound
  int unsigned wr_wait;
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || !tap_transaction_pending_o || (state == ARB_TAP)) begin
      wr_wait <= 0;
    end else if (tap_we && wr_wait < 1000) begin
      wr_wait <= wr_wait + 1;
    end
  end

  AST_CAPTURE_PAD: assert property (
    do_capture |=> (dr_word == {`CAPTURE_PAD, $past(held_data)}))
    else $error("captured word not padded port data");
  AST_SELECT_ONLY: assert property (
    (tck_rise && capture_s && !selected) |=> $stable(dr_word))
    else $error("data register moved without monitor opcode");
  AST_PENDING_RISE: assert property (
    (update_take && dr_valid) |=> tap_transaction_pending_o)
    else $error("pending flag did not rise at update");
  AST_NOP_IGNORED: assert property (
    (update_take && !dr_valid && !tap_transaction_pending_o)
    |=> !tap_transaction_pending_o ##1 (state != ARB_TAP))
    else $error("nop or undefined code started an access");
  AST_WRITE_REACH: assert property (
    wr_wait <= `WRITE_REACH_CYCLES)
    else $error("tap write not issued within six cycles");
  AST_ONE_OWNER: assert property (
    $onehot(state) && (!cfg_en_o || ($past(state) == ARB_IDLE)))
    else $error("port granted twice or state corrupt");
  AST_FAB_AFTER_TAP: assert property (
    (state == ARB_TAP) |-> !fab_done)
    else $error("fabric finished during tap transaction");
  AST_TAP_WAITS: assert property (
    (state == ARB_FAB && !cfg_ready_i) |=> (state != ARB_TAP))
    else $error("tap interrupted fabric transaction");
  AST_WROTE_SET: assert property (
    (tap_done && cfg_we_o) |=> tap_wrote_flag_o && !tap_transaction_pending_o)
    else $error("wrote flag missing after tap write");
  AST_LOCK_REFUSE: assert property (
    (tap_lockout_flag_o && fab_pend && state == ARB_IDLE &&
     !tap_transaction_pending_o) |=> fab_refused_o && !cfg_en_o)
    else $error("locked fabric access was not refused");
  AST_AUX_PRECONFIG: assert property (
    $rose(aux_inputs_en_o) |-> !$past(configured_i))
    else $error("aux enable set after configuration");
  AST_READ_HELD: assert property (
    (tap_done && !cfg_we_o) |=> (held_data == $past(cfg_do_i)))
    else $error("tap read result not held");

endmodule : jtag_config_port_bridge

`default_nettype wire

// File: include/jtag_config_port_bridge_consts.svh
`ifndef JTAG_CONFIG_PORT_BRIDGE_CONSTS_SVH
`define JTAG_CONFIG_PORT_BRIDGE_CONSTS_SVH

// instruction that routes data scans to the monitor register
`define MONITOR_ACCESS_OPCODE 10'h3F7
`define IR_WIDTH 10

// command word layout
`define CMD_WIDTH 32
`define CMD_DATA_LSB 0
`define CMD_DATA_MSB 15
`define CMD_ADDR_LSB 16
`define CMD_ADDR_MSB 25
`define CMD_OP_LSB 26
`define CMD_OP_MSB 29
`define PORT_DATA_WIDTH 16
`define PORT_ADDR_WIDTH 10
`define CAPTURE_PAD 16'h0000

// operation codes
`define OP_NOP 4'h0
`define OP_READ 4'h1
`define OP_WRITE 4'h2

// special port locations and values
`define LOCK_ADDR 10'h000
`define LOCK_SET_VALUE 16'h0001
`define LOCK_CLEAR_VALUE 16'h0000
`define AUX_ENABLE_ADDR 10'h002
`define AUX_ENABLE_VALUE 16'h0001

// reset values
`define HELD_DATA_RESET 16'h0000

// longest handoff of a write to the port, in port clock cycles
`define WRITE_REACH_CYCLES 6

`endif

// File: include/jtag_config_port_bridge_pkg.sv
`default_nettype none

package jtag_config_port_bridge_pkg;

  // owner of the configuration port, one whole transaction at a time
  typedef enum logic [2:0] {
    ARB_IDLE = 3'b001,
    ARB_FAB = 3'b010,
    ARB_TAP = 3'b100
  } arb_state_e;

  typedef logic [3:0] port_op_t;

endpackage : jtag_config_port_bridge_pkg

`default_nettype wire

// File: rtl/tap_data_register.sv
`include "jtag_config_port_bridge_consts.svh"
`default_nettype none

// capture/shift register, lsb leaves first, msb takes the new bit
module tap_data_register #(
  parameter int WIDTH = `CMD_WIDTH
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic capture_i,
  input wire logic shift_i,
  input wire logic serial_i,
  input wire logic [WIDTH-1:0] load_i,
  output logic [WIDTH-1:0] word_o,
  output logic serial_o
);

  // capture wins if both strobes arrive together
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      word_o <= '0;
    end else if (capture_i) begin
      word_o <= load_i;
    end else if (shift_i) begin
      word_o <= {serial_i, word_o[WIDTH-1:1]};
    end
  end

  assign serial_o = word_o[0];

endmodule : tap_data_register

`default_nettype wire

// File: testbench/cfg_port_model.sv
`include "jtag_config_port_bridge_consts.svh"
`default_nettype none

// register space behind the configuration port, quick or slow to answer
module cfg_port_model (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic slow_i,
  input wire logic cfg_en_i,
  input wire logic cfg_we_i,
  input wire logic [`PORT_ADDR_WIDTH-1:0] cfg_addr_i,
  input wire logic [`PORT_DATA_WIDTH-1:0] cfg_di_i,
  output logic [`PORT_DATA_WIDTH-1:0] cfg_do_o,
  output logic cfg_ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [`PORT_DATA_WIDTH-1:0] mem [0:1023];
  logic [5:0] wait_cnt;
  logic busy;

  initial begin
    for (int i = 0; i < 1024; i++) begin
      mem[i] = 16'h0000;
    end
  end

  // read data toggles outside ready so a stale sample never looks valid
  always @(posedge core_clk_i) begin
    cfg_ready_o <= 1'h0;
    cfg_do_o <= ~cfg_do_o;
    if (!rst_n_i) begin
      busy <= 1'h0;
      wait_cnt <= 6'h00;
      cfg_do_o <= 16'hA5A5;
    end else if (cfg_en_i) begin
      busy <= 1'h1;
      wait_cnt <= slow_i ? 6'h1E : 6'h00;
    end else if (busy && wait_cnt == 6'h00) begin
      busy <= 1'h0;
      cfg_ready_o <= 1'h1;
      if (cfg_we_i) begin
        mem[cfg_addr_i] <= cfg_di_i;
      end else begin
        cfg_do_o <= mem[cfg_addr_i];
      end
    end else if (busy) begin
      wait_cnt <= wait_cnt - 6'h01;
    end
  end
endmodule : cfg_port_model

`default_nettype wire

// File: testbench/jtag_config_port_bridge_tb_top.sv
`include "jtag_config_port_bridge_consts.svh"
`default_nettype none

module jtag_config_port_bridge_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i = 0, rst_n_i = 0, tck = 0, tdi = 0, tdo;
  logic cap = 0, sh = 0, upd = 0, configured = 0, slow = 0;
  logic [9:0] ir = `MONITOR_ACCESS_OPCODE;
  logic fab_en = 0, fab_we = 0, fab_ready, fab_refused;
  logic [9:0] fab_addr = 0, cfg_addr;
  logic [15:0] fab_di = 0, fab_do, cfg_di, cfg_do;
  logic cfg_en, cfg_we, cfg_ready, pend, wrote, lock, aux;
  int mismatches = 0, cmp_count = 0, cycles = 0, seed = 55361;

  jtag_config_port_bridge dut_u (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .tck_i(tck), .tdi_i(tdi), .tdo_o(tdo), .ir_value_i(ir),
    .capture_dr_i(cap), .shift_dr_i(sh), .update_dr_i(upd),
    .configured_i(configured), .fab_en_i(fab_en), .fab_we_i(fab_we),
    .fab_addr_i(fab_addr), .fab_di_i(fab_di), .fab_do_o(fab_do),
    .fab_ready_o(fab_ready), .fab_refused_o(fab_refused),
    .cfg_en_o(cfg_en), .cfg_we_o(cfg_we), .cfg_addr_o(cfg_addr),
    .cfg_di_o(cfg_di), .cfg_do_i(cfg_do), .cfg_ready_i(cfg_ready),
    .tap_transaction_pending_o(pend), .tap_wrote_flag_o(wrote),
    .tap_lockout_flag_o(lock), .aux_inputs_en_o(aux));

  cfg_port_model model_u (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .slow_i(slow), .cfg_en_i(cfg_en), .cfg_we_i(cfg_we),
    .cfg_addr_i(cfg_addr), .cfg_di_i(cfg_di), .cfg_do_o(cfg_do),
    .cfg_ready_o(cfg_ready));

  always #20 core_clk_i = ~core_clk_i;

  task automatic summarize;
    if (mismatches == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize

  // hang guard, generous against roughly 12k cycles of traffic
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      summarize();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [31:0] cmd(input logic [3:0] op,
    input logic [9:0] a, input logic [15:0] d);
    return {2'h0, op, a, d};
  endfunction : cmd

  // one tck period of 8 core clocks; controls move just after the rise
  task automatic step(input logic c, s, u, d, output logic q);
    tck = 1'h1;
    @(negedge core_clk_i);
    cap = c;
    sh = s;
    upd = u;
    tdi = d;
    repeat (3) @(negedge core_clk_i);
    tck = 1'h0;
    repeat (4) @(negedge core_clk_i);
    q = tdo;
  endtask : step

  // capture, 32 shifts lsb first, update, then run-test-idle
  task automatic scan(input logic [31:0] c, input int rti,
    output logic [31:0] got);
    logic q;
    step(1'h1, 1'h0, 1'h0, 1'h0, q);
    for (int i = 0; i < 32; i++) begin
      step(1'h0, 1'h1, 1'h0, c[i], got[i]);
    end
    step(1'h0, 1'h0, 1'h1, 1'h0, q);
    repeat (rti + 1) step(1'h0, 1'h0, 1'h0, 1'h0, q);
  endtask : scan

  // single request pulse, then wait for ready; one access at a time
  task automatic fab(input logic we, input logic [9:0] a,
    input logic [15:0] d, output logic [15:0] q, output logic r);
    int n;
    fab_en = 1'h1;
    fab_we = we;
    fab_addr = a;
    fab_di = d;
    @(negedge core_clk_i);
    fab_en = 1'h0;
    for (n = 0; n < 200 && fab_ready !== 1'h1; n++) @(negedge core_clk_i);
    check({31'h0, fab_ready}, 32'h1);
    check({31'h0, pend}, 32'h0);
    q = fab_do;
    r = fab_refused;
    @(negedge core_clk_i);
  endtask : fab

  initial begin
    logic [31:0] got;
    logic [15:0] q, d;
    logic [15:0] dat [4];
    logic [9:0] adr [4];
    logic r;
    repeat (3) @(negedge core_clk_i);
    check({28'h0, pend, wrote, lock, aux}, 32'h0);
    rst_n_i = 1'h1;
    repeat (3) @(negedge core_clk_i);
    // tap writes with random data
    for (int i = 0; i < 4; i++) begin
      adr[i] = 10'h040 + 10'(i * 3);
      dat[i] = 16'($random(seed));
      scan(cmd(`OP_WRITE, adr[i], dat[i]), 10, got);
      check({16'h0, model_u.mem[adr[i]]}, {16'h0, dat[i]});
      check({31'h0, wrote}, 32'h1);
    end
    // pipelined reads: each scan shifts out the previous result
    scan(cmd(`OP_READ, adr[0], 16'h0), 10, got);
    check({31'h0, wrote}, 32'h0);
    for (int i = 1; i < 5; i++) begin
      scan(cmd(i < 4 ? `OP_READ : `OP_NOP, adr[i % 4], 16'h0), 10, got);
      check(got, {16'h0, dat[i - 1]});
    end
    // fabric access clears the wrote flag and round-trips data
    scan(cmd(`OP_WRITE, 10'h050, 16'($random(seed))), 10, got);
    d = 16'($random(seed));
    fab(1'h1, 10'h060, d, q, r);
    check({15'h0, wrote, model_u.mem[10'h060]}, {16'h0, d});
    fab(1'h0, 10'h060, 16'h0, q, r);
    check({15'h0, r, q}, {16'h0, d});
    // lockout refuses fabric until cleared
    scan(cmd(`OP_WRITE, `LOCK_ADDR, `LOCK_SET_VALUE), 10, got);
    fab(1'h1, 10'h060, ~d, q, r);
    check({14'h0, lock, r, model_u.mem[10'h060]}, {16'h3, d});
    scan(cmd(`OP_WRITE, `LOCK_ADDR, `LOCK_CLEAR_VALUE), 10, got);
    fab(1'h0, 10'h060, 16'h0, q, r);
    check({14'h0, lock, r, q}, {16'h0, d});
    // auxiliary enable only before configuration
    scan(cmd(`OP_WRITE, `AUX_ENABLE_ADDR, `AUX_ENABLE_VALUE), 10, got);
    check({31'h0, aux}, 32'h1);
    configured = 1'h1;
    repeat (4) @(negedge core_clk_i);
    check({31'h0, aux}, 32'h0);
    fab(1'h1, `AUX_ENABLE_ADDR, `AUX_ENABLE_VALUE, q, r);
    check({31'h0, aux}, 32'h0);
    // other instruction: scans must not reach the port
    ir = 10'h000;
    scan(cmd(`OP_WRITE, 10'h060, ~d), 10, got);
    check({15'h0, pend, model_u.mem[10'h060]}, {16'h0, d});
    ir = `MONITOR_ACCESS_OPCODE;
    // every code apart from read and write leaves the port alone
    for (int op = 0; op < 16; op++) begin
      if (op != 1 && op != 2) begin
        scan(cmd(4'(op), 10'h060, ~d), 10, got);
        check({16'h0, model_u.mem[10'h060]}, {16'h0, d});
      end
    end
    // slow port: capture too early sees the older held word
    slow = 1'h1;
    scan(cmd(`OP_READ, 10'h060, 16'h0), 10, got);
    scan(cmd(`OP_READ, adr[1], 16'h0), 0, got);
    check(got, {16'h0, d});
    scan(cmd(`OP_NOP, 10'h000, 16'h0), 10, got);
    check(got, {16'h0, d});
    scan(cmd(`OP_NOP, 10'h000, 16'h0), 10, got);
    check(got, {16'h0, dat[1]});
    // fabric request while a tap write is pending waits its turn
    fork
      scan(cmd(`OP_WRITE, adr[2], d), 10, got);
      begin
        for (int n = 0; n < 500 && pend !== 1'h1; n++) begin
          @(negedge core_clk_i);
        end
        fab(1'h1, adr[3], ~d, q, r);
      end
    join
    check({model_u.mem[adr[2]], model_u.mem[adr[3]]}, {d, ~d});
    slow = 1'h0;
    summarize();
  end
endmodule : jtag_config_port_bridge_tb_top

`default_nettype wire
